// ==== snvm_spi_slave.v ====
// spi slave front end and byte array of the serial nonvolatile memory
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "snvm_map.vh"
module snvm_spi_slave #(
   parameter DEPTH = `SNVM_DEPTH,
   parameter AW = `SNVM_ADDR_W,
   parameter FIFO_DEPTH = `SNVM_FIFO_DEPTH
) (
   input wire clock,
   input wire resetn,
   input wire cs_n,
   input wire sck,
   input wire si,
   input wire hold_n,
   input wire wp_n,
   output reg so_out,
   output reg so_oe_n,
   output wire write_enable_latch,
   output wire [1:0] block_protect,
   output wire protect_pin_enable_bit
);
   // sequencer phases of one selection cycle
   localparam ST_OPC = 3'h0;
   localparam ST_AHI = 3'h1;
   localparam ST_ALO = 3'h2;
   localparam ST_WDAT = 3'h3;
   localparam ST_RDAT = 3'h4;
   localparam ST_SWR = 3'h5;
   localparam ST_SRD = 3'h6;
   localparam ST_IGN = 3'h7;
   // buffer word: array address above the data byte
   localparam FW = AW + 8;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg [4:0] sync1;
   reg [4:0] sync2;
   reg sck_prev;
   reg cs_eff;
   // synchronised copies of the pins
   wire cs_s = sync2[0];
   wire sck_s = sync2[1];
   wire si_s = sync2[2];
   wire hold_s = sync2[3];
   wire wp_s = sync2[4];

   // two flops on every outside input, first stage read only by second
   always @(posedge clock) begin
      if (!resetn) begin
         sync1 <= `SNVM_PIN_IDLE;
         sync2 <= `SNVM_PIN_IDLE;
      end else begin
         sync1 <= {wp_n, hold_n, si, sck, cs_n};
         sync2 <= sync1;
      end
   end

   // select and clock edges are frozen while hold is low
   always @(posedge clock) begin
      if (!resetn) begin
         cs_eff <= 1'b1;
         sck_prev <= 1'b0;
      end else if (hold_s) begin
         cs_eff <= cs_s;
         sck_prev <= sck_s;
      end
   end

   // edges only count while selected and not held; there is no timer,
   // so the serial clock may stop for any length of time
   wire active = hold_s & ~cs_eff & ~cs_s;
   wire sck_rise = active & sck_s & ~sck_prev;
   wire sck_fall = active & ~sck_s & sck_prev;
   // select released: closes the frame
   wire cs_rise = hold_s & cs_s & ~cs_eff;

   // ---------------------------------------------------------------
   // status register
   // ---------------------------------------------------------------
   // write enable latch, pin enable and block protect code
   reg wel;
   reg pin_en;
   reg [1:0] bp;
   assign write_enable_latch = wel;
   assign block_protect = bp;
   assign protect_pin_enable_bit = pin_en;

   // status byte as returned to the master
   wire [7:0] status_byte;
   assign status_byte = {pin_en, 3'h0, bp, wel, 1'b0};

   // ---------------------------------------------------------------
   // receive shifter and command sequencer
   // ---------------------------------------------------------------
   // phase, bit counters, shifters and the pending buffer word
   reg [2:0] state;
   reg [2:0] bit_cnt;
   reg [6:0] rx;
   reg [AW-1:0] addr;
   reg [AW-9:0] addr_hi;
   reg [7:0] tx;
   reg [2:0] tx_cnt;
   reg tx_on;
   reg wr_valid;
   reg [FW-1:0] wr_word;
   reg clear_wel;

   // the byte as it completes, newest bit in the lsb
   wire [7:0] rx_byte = {rx, si_s};
   wire byte_done = sck_rise & (bit_cnt == `SNVM_LAST_BIT);
   wire [AW-1:0] addr_full = {addr_hi, rx_byte};
   wire fifo_in_ready;
   wire status_locked = pin_en & ~wp_s;
   reg [7:0] mem [0:DEPTH-1];

   // block protect decode on the write address
   reg prot_hit;
   always @* begin
      case (bp)
         `SNVM_BP_NONE: prot_hit = 1'b0;
         `SNVM_BP_QUARTER: prot_hit = (addr >= `SNVM_QUARTER_BASE);
         `SNVM_BP_HALF: prot_hit = (addr >= `SNVM_HALF_BASE);
         default: prot_hit = 1'b1;
      endcase
   end

   // sequencer, shifters and status bits
   always @(posedge clock) begin
      if (!resetn) begin
         state <= ST_OPC;
         bit_cnt <= 3'h0;
         rx <= 7'h00;
         addr <= {AW{1'b0}};
         addr_hi <= {(AW-8){1'b0}};
         tx <= 8'h00;
         tx_cnt <= 3'h0;
         tx_on <= 1'b0;
         wr_valid <= 1'b0;
         wr_word <= {FW{1'b0}};
         clear_wel <= 1'b0;
         wel <= 1'b0;
         pin_en <= 1'b0;
         bp <= 2'h0;
         so_out <= 1'b0;
      end else begin
         // the buffer took the pending word
         if (wr_valid && fifo_in_ready)
            wr_valid <= 1'b0;
         // deselected: back to the opcode phase
         if (cs_eff) begin
            state <= ST_OPC;
            bit_cnt <= 3'h0;
            tx_on <= 1'b0;
            tx_cnt <= 3'h0;
         end
         // write enable drops once the frame that used it is over
         if (cs_rise && clear_wel) begin
            wel <= 1'b0;
            clear_wel <= 1'b0;
         end
         // shift one bit in; stall while the buffer cannot take a word
         if (sck_rise && !(wr_valid && !fifo_in_ready)) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx <= rx_byte[6:0];
         end
         // a whole byte is in: act on it by phase
         if (byte_done && !(wr_valid && !fifo_in_ready)) begin
            case (state)
               ST_OPC: begin
                  case (rx_byte)
                     `SNVM_OP_WREN: begin
                        wel <= 1'b1;
                        state <= ST_IGN;
                     end
                     `SNVM_OP_WR_DIS: begin
                        wel <= 1'b0;
                        state <= ST_IGN;
                     end
                     `SNVM_OP_RDSR: begin
                        tx <= status_byte;
                        state <= ST_SRD;
                     end
                     `SNVM_OP_WRSR: state <= ST_SWR;
                     `SNVM_OP_READ: state <= ST_AHI;
                     `SNVM_OP_WRITE: state <= ST_AHI;
                     default: state <= ST_IGN;
                  endcase
                  wr_word[7:0] <= rx_byte;   // opcode kept for address phase
               end
               ST_AHI: begin
                  addr_hi <= rx_byte[AW-9:0];
                  state <= ST_ALO;
               end
               // a read fetches its first byte at once, a write waits
               ST_ALO: begin
                  if (wr_word[7:0] == `SNVM_OP_READ) begin
                     tx <= mem[addr_full];
                     addr <= addr_full + 1'b1;
                     state <= ST_RDAT;
                  end else begin
                     addr <= addr_full;
                     state <= ST_WDAT;
                  end
               end
               ST_WDAT: begin
                  if (wel && !prot_hit) begin
                     wr_valid <= 1'b1;
                     wr_word <= {addr, rx_byte};
                  end
                  addr <= addr + 1'b1;
                  clear_wel <= 1'b1;
               end
               ST_SWR: begin
                  if (wel && !status_locked) begin
                     pin_en <= rx_byte[`SNVM_ST_PIN_EN];
                     bp <= rx_byte[`SNVM_ST_BP_HI:`SNVM_ST_BP_LO];
                     clear_wel <= 1'b1;
                  end
                  state <= ST_IGN;
               end
               default: state <= state;
            endcase
         end
         // output shifter runs on falling edges in read phases
         if (sck_fall && (state == ST_RDAT || state == ST_SRD)) begin
            so_out <= tx[7];
            tx_on <= 1'b1;
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == `SNVM_LAST_BIT) begin
               if (state == ST_RDAT) begin
                  tx <= mem[addr];
                  addr <= addr + 1'b1;
               end else
                  tx <= status_byte;
            end else
               tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // output enable low only while read data is on the pin
   always @(posedge clock) begin
      if (!resetn)
         so_oe_n <= 1'b1;
      else
         so_oe_n <= ~(tx_on & hold_s & ~cs_s & ~cs_eff &
                      (state == ST_RDAT || state == ST_SRD));
   end

   // ---------------------------------------------------------------
   // write buffer into the array
   // ---------------------------------------------------------------
   wire fifo_out_valid;
   wire [FW-1:0] fifo_out_data;
   // the array read port serves the read prefetch on a falling edge, so
   // the buffer holds its word for that one clock
   wire drain_ready = ~(sck_fall & (state == ST_RDAT));

   snvm_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_wbuf (
      .clock(clock),
      .resetn(resetn),
      .in_valid(wr_valid),
      .in_ready(fifo_in_ready),
      .in_data(wr_word),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready),
      .out_data(fifo_out_data)
   );

   // array commit as each byte leaves the buffer, no busy period
   always @(posedge clock) begin
      if (fifo_out_valid && drain_ready)
         mem[fifo_out_data[FW-1:8]] <= fifo_out_data[7:0];
   end
endmodule
`default_nettype wire

// ==== snvm_map.vh ====
// constants for the serial nonvolatile memory slave
`ifndef SNVM_MAP_VH
`define SNVM_MAP_VH
// array geometry
`define SNVM_ADDR_W 13
`define SNVM_DEPTH 8192
`define SNVM_QUARTER_BASE 13'h1800
`define SNVM_HALF_BASE 13'h1000
// command opcodes
`define SNVM_OP_WREN 8'h06
`define SNVM_OP_WR_DIS 8'h04
`define SNVM_OP_RDSR 8'h05
`define SNVM_OP_WRSR 8'h01
`define SNVM_OP_READ 8'h03
`define SNVM_OP_WRITE 8'h02
// status register layout
`define SNVM_ST_PIN_EN 7
`define SNVM_ST_BP_HI 3
`define SNVM_ST_BP_LO 2
`define SNVM_ST_WEL 1
`define SNVM_ST_RESET 8'h00
// block protect codes
`define SNVM_BP_NONE 2'h0
`define SNVM_BP_QUARTER 2'h1
`define SNVM_BP_HALF 2'h2
// bit counter end value and write buffer depth
`define SNVM_LAST_BIT 3'h7
`define SNVM_FIFO_DEPTH 16
// idle pin levels {wp_n, hold_n, si, sck, cs_n} loaded into the synchronisers
`define SNVM_PIN_IDLE 5'h19
`endif

// ==== snvm_fifo.v ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module snvm_fifo #(
   parameter WIDTH = 21,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clock,
   input wire resetn,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // honest full and empty from the occupancy count
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = store[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // pointers and count
   always @(posedge clock) begin
      if (!resetn) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

   // storage write, no reset needed
   always @(posedge clock) begin
      if (push)
         store[wr_ptr] <= in_data;
   end
endmodule
`default_nettype wire

// ==== snvm_spi_slave_assertions.sv ====
// checker watching the ports of the serial memory slave
`timescale 1ns/1ps
`default_nettype none
module snvm_spi_slave_assertions (
   input wire logic clock,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_out,
   input wire logic so_oe_n,
   input wire logic write_enable_latch,
   input wire logic [1:0] block_protect,
   input wire logic protect_pin_enable_bit
);
   logic sck_q = 1'b0;
   logic [3:0] since_fall = 4'hF;
   // count clocks since the serial clock pin last fell, saturating
   always @(posedge clock) begin
      sck_q <= sck;
      since_fall <= (sck_q && !sck) ? 4'h0 :
         (since_fall == 4'hF) ? 4'hF : since_fall + 4'h1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_reset_quiet: assert property (disable iff (1'b0) !resetn |=>
      so_oe_n && !write_enable_latch && block_protect == 2'h0
      && !protect_pin_enable_bit) else $error("reset state wrong");
   chk_standby_release: assert property (cs_n [*5] |-> so_oe_n)
      else $error("output driven while deselected");
   chk_hold_release: assert property (!hold_n [*5] |-> so_oe_n)
      else $error("output driven during hold");
   chk_oe_select: assert property ($fell(so_oe_n) |->
      !$past(cs_n, 2) && $past(hold_n, 2)) else $error("bad drive start");
   chk_out_on_fall: assert property ($changed(so_out) && !so_oe_n
      && !$past(so_oe_n) |-> since_fall inside {[1:6]})
      else $error("output changed away from clock fall");
   chk_standby_stable: assert property (cs_n [*6] |=>
      $stable(write_enable_latch) && $stable(block_protect)
      && $stable(protect_pin_enable_bit)) else $error("status moved");
   chk_hold_freeze: assert property (!hold_n [*5] |=>
      $stable(so_out) && $stable(write_enable_latch))
      else $error("state moved during hold");
   chk_pin_gate: assert property (
      (protect_pin_enable_bit && !wp_n) [*6]
      |=> $stable(block_protect) && protect_pin_enable_bit)
      else $error("status written while pin protected");
   cover property ($fell(so_oe_n));
   cover property (!hold_n [*5]);
   cover property (protect_pin_enable_bit && !wp_n);
   cover property ($rose(write_enable_latch));
endmodule
`default_nettype wire

// ==== snvm_master.sv ====
// spi bus master model driving the slave pins
`timescale 1ns/1ps
`default_nettype none
module snvm_master (
   input wire logic clock,
   input wire logic so_out,
   input wire logic so_oe_n,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   logic cpol = 1'b0; // low for mode 0, high for mode 3
   int hold_bit = -1; // bit index where a hold pause is inserted
   logic drove = 1'b0; // slave drove its output in this frame
   // idle pins at time zero
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   logic cs_q = 1'b1; // select level at the previous clock
   // note any drive of the output in a frame, cleared as the frame opens
   always @(posedge clock) begin
      cs_q <= cs_n;
      if (cs_q && !cs_n)
         drove <= 1'b0;
      else if (!cs_n && so_oe_n === 1'b0)
         drove <= 1'b1;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge clock);
   endtask
   // fresh select for every opcode
   task automatic start();
      sck = cpol;
      wait_n(4);
      cs_n = 1'b0;
      wait_n(4);
   endtask
   // released data line shows the inverse of its last value
   task automatic stop();
      sck = cpol;
      wait_n(4);
      cs_n = 1'b1;
      si = ~si;
      wait_n(6);
   endtask
   // hold moves only while the clock is low; clock toggles meanwhile
   task automatic pause();
      wait_n(2);
      hold_n = 1'b0;
      wait_n(4);
      sck = 1'b1;
      wait_n(4);
      sck = 1'b0;
      wait_n(4);
      hold_n = 1'b1;
      wait_n(2);
   endtask
   // one byte each way, msb first, 400 ns clock period
   task automatic xfer(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si = d[i];
         if (i == hold_bit) pause();
         wait_n(4);
         sck = 1'b1;
         wait_n(4);
         q[i] = so_oe_n ? ~so_out : so_out;
      end
   endtask
endmodule
`default_nettype wire

// ==== snvm_spi_slave_tb.sv ====
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none
`include "snvm_map.vh"
module snvm_spi_slave_tb;
   typedef struct {logic cpol; logic [15:0] wa, ra, d;} snvm_row_t;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   wire cs_n, sck, si, hold_n, so_out, so_oe_n, wel, pin_en;
   wire [1:0] bp;
   int fail_count = 0;
   int checks = 0;
   logic [7:0] rx[$];
   logic [15:0] rv, base;
   snvm_row_t rows[4] = '{'{1'b0, 16'h0000, 16'h0000, 16'hA53C},
      '{1'b0, 16'hE005, 16'h0005, 16'h8001},
      '{1'b1, 16'h1FFE, 16'hFFFE, 16'h7EC3},
      '{1'b1, 16'h0FF0, 16'h0FF0, 16'h0102}};
   always #25 clock = ~clock;
   snvm_spi_slave DUT (.clock(clock), .resetn(resetn), .cs_n(cs_n),
      .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out),
      .so_oe_n(so_oe_n), .write_enable_latch(wel), .block_protect(bp),
      .protect_pin_enable_bit(pin_en));
   snvm_master m (.clock(clock), .so_out(so_out), .so_oe_n(so_oe_n),
      .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
   task automatic chk(input logic [15:0] seen, exp, input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic frame(input logic [7:0] tx[$]);
      logic [7:0] b;
      m.start();
      rx.delete();
      foreach (tx[i]) begin
         m.xfer(tx[i], b);
         rx.push_back(b);
      end
      m.stop();
   endtask
   task automatic wren();
      frame({`SNVM_OP_WREN});
   endtask
   task automatic wrsr(input logic [7:0] v);
      wren();
      frame({`SNVM_OP_WRSR, v});
   endtask
   task automatic wr(input logic [15:0] a, d);
      wren();
      frame({`SNVM_OP_WRITE, a[15:8], a[7:0], d[15:8], d[7:0]});
   endtask
   task automatic rd(input logic [15:0] a);
      frame({`SNVM_OP_READ, a[15:8], a[7:0], 8'h00, 8'h00});
      rv = {rx[3], rx[4]};
   endtask
   task automatic done(input string s);
      $display("test %s finished, %0d mismatches so far", s, fail_count);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      repeat (80000) @(posedge clock);
      fail_count++;
      $display("Error watchdog expected done seen timeout");
      close_out();
   end
   // main sequence, inputs change on the falling clock edge
   initial begin
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      repeat (4) @(negedge clock);
      chk({so_oe_n, wel, bp, pin_en}, 16'h0010, "power-on");
      foreach (rows[i]) begin
         m.cpol = rows[i].cpol;
         wr(rows[i].wa, rows[i].d);
         rd(rows[i].ra);
         chk(rv, rows[i].d, "row read");
      end
      done("rows");
      wr(16'h0040, 16'h1234);
      wren();
      chk(wel, 16'h0001, "wel set");
      frame({`SNVM_OP_WR_DIS});
      chk(wel, 16'h0000, "wel cleared");
      frame({`SNVM_OP_WRITE, 8'h00, 8'h40, 8'hAB, 8'hCD});
      rd(16'h0040);
      chk(rv, 16'h1234, "write refused");
      done("disable");
      for (int k = 1; k < 4; k++) begin
         base = (k == 1) ? `SNVM_QUARTER_BASE :
            (k == 2) ? `SNVM_HALF_BASE : 16'h0000;
         wr(base, 16'h1111);
         wrsr({4'h0, k[1:0], 2'h0});
         chk(bp, {14'h0000, k[1:0]}, "protect code");
         wr(base, 16'hEEEE);
         rd(base);
         chk(rv, 16'h1111, "protected write");
      end
      wrsr(8'h00);
      done("protect");
      wrsr(8'h80);
      chk(pin_en, 16'h0001, "pin enable");
      wren();
      frame({`SNVM_OP_RDSR, 8'h00, 8'h00});
      chk(rx[1], 16'h0082, "status read");
      chk(rx[2], 16'h0082, "status repeat");
      wp_n = 1'b0;
      wrsr(8'h8C);
      chk(bp, 16'h0000, "gated status write");
      wp_n = 1'b1;
      wrsr(8'h00);
      chk(pin_en, 16'h0000, "open status write");
      done("pin gate");
      m.hold_bit = 3;
      wr(16'h0123, 16'h5A5A);
      rd(16'h0123);
      m.hold_bit = -1;
      chk(rv, 16'h5A5A, "hold resume");
      done("hold");
      wren();
      frame({8'hFF, `SNVM_OP_WRITE, 8'h00, 8'h60, 8'h99});
      chk(m.drove, 16'h0000, "no drive");
      chk(wel, 16'h0001, "rest ignored");
      done("invalid");
      resetn = 1'b0;
      repeat (2) @(negedge clock);
      chk({so_oe_n, wel, bp, pin_en}, 16'h0010, "reset values");
      resetn = 1'b1;
      done("reset");
      close_out();
   end
endmodule
bind snvm_spi_slave snvm_spi_slave_assertions chk_i (.clock(clock),
   .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
   .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n),
   .write_enable_latch(write_enable_latch), .block_protect(block_protect),
   .protect_pin_enable_bit(protect_pin_enable_bit));
`default_nettype wire
